/* File: pkg/lcdi_regs.vh */
`ifndef LCDI_REGS_VH
`define LCDI_REGS_VH

// register byte offsets
`define LCDI_OFS_STATUS 8'h00
`define LCDI_OFS_FUNC 8'h04
`define LCDI_OFS_DISP 8'h08
`define LCDI_OFS_ENTRY 8'h0C
`define LCDI_OFS_ADDR 8'h10
`define LCDI_OFS_DATA 8'h14
`define LCDI_OFS_CTRL 8'h18
`define LCDI_OFS_STATE 8'h1C

// status fields
`define LCDI_ST_FLAG_BIT 7
`define LCDI_ST_AC_MSB 6

// function fields
`define LCDI_FN_WIDTH_BIT 4
`define LCDI_FN_LINES_BIT 3
`define LCDI_FN_FONT_BIT 2

// display fields
`define LCDI_DP_ON_BIT 2
`define LCDI_DP_CURSOR_BIT 1
`define LCDI_DP_BLINK_BIT 0

// entry fields
`define LCDI_EN_INC_BIT 1
`define LCDI_EN_SHIFT_BIT 0

// control fields
`define LCDI_CT_RESTART_BIT 0

// defaults loaded by the power-on sequence
`define LCDI_DEF_WIDTH 1'b1
`define LCDI_DEF_LINES 1'b0
`define LCDI_DEF_FONT 1'b0
`define LCDI_DEF_ON 1'b0
`define LCDI_DEF_CURSOR 1'b0
`define LCDI_DEF_BLINK 1'b0
`define LCDI_DEF_INC 1'b1
`define LCDI_DEF_SHIFT 1'b0
`define LCDI_CLEAR_CODE 8'h20

// text memory
`define LCDI_MEM_DEPTH 80
`define LCDI_MEM_AW 7
`define LCDI_MEM_LAST 7'h4F

// sequencer step rate: internal oscillator in kHz, clock in kHz
`define LCDI_FOSC_KHZ 540
`define LCDI_CLK_KHZ 125000
`define LCDI_STEP_CYC (`LCDI_CLK_KHZ / `LCDI_FOSC_KHZ)

`endif

/* File: hdl/lcdi_txtmem.v */
`timescale 1ns/1ns
`default_nettype none

// display text storage, flip-flops, registered read
module lcdi_txtmem #(
	parameter DEPTH = 80,
	parameter AW = 7,
	parameter DW = 8
) (
	input wire pclk,
	input wire presetn,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);

	reg [DW-1:0] mem_r [0:DEPTH-1];

	always @(posedge pclk)
	begin
		if (wr_en)
			mem_r[wr_addr] <= wr_data;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data <= {DW{1'b0}};
		else
			rd_data <= mem_r[rd_addr];
	end

endmodule

`default_nettype wire

/* File: hdl/lcdi_init.v */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "lcdi_regs.vh"

module lcdi_init #(
	parameter STEP_CYC = `LCDI_STEP_CYC,
	parameter DEPTH = `LCDI_MEM_DEPTH
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg internal_op_flag,
	output reg bus_width_select,
	output reg line_count_select,
	output reg font_select,
	output reg display_on,
	output reg cursor_show,
	output reg blink_enable
);

	localparam AW = `LCDI_MEM_AW;
	localparam [4:0] ST_CLEAR = 5'h01;
	localparam [4:0] ST_FUNC = 5'h02;
	localparam [4:0] ST_DISP = 5'h04;
	localparam [4:0] ST_ENTRY = 5'h08;
	localparam [4:0] ST_READY = 5'h10;
	localparam [AW-1:0] LAST_ADDR = `LCDI_MEM_LAST;

	// next address after an access, wrapping inside the text memory
	function [AW-1:0] ac_step;
		input [AW-1:0] ac;
		input inc;
		begin
			if (inc)
				ac_step = (ac == LAST_ADDR) ? {AW{1'b0}} : ac + 7'h01;
			else
				ac_step = (ac == {AW{1'b0}}) ? LAST_ADDR : ac - 7'h01;
		end
	endfunction

	reg [4:0] state_r;
	reg [15:0] div_r;
	reg step_en_r;
	reg [AW-1:0] clr_addr_r;
	reg [AW-1:0] ac_r;
	reg addr_inc_r;
	reg disp_shift_r;
	reg [AW-1:0] mem_wa;
	reg [7:0] mem_wd;
	reg mem_we;
	wire [7:0] mem_rd;
	wire access;
	wire wr_acc;
	wire rd_acc;
	wire busy;
	reg [31:0] rdata_nxt;
	reg err_nxt;

	assign access = psel & penable & ~pready;
	assign wr_acc = access & pwrite;
	assign rd_acc = access & ~pwrite;
	assign busy = internal_op_flag;

	// step rate divider for the sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_r <= 16'h0000;
			step_en_r <= 1'b0;
		end
		else if (div_r == STEP_CYC[15:0] - 16'h0001)
		begin
			div_r <= 16'h0000;
			step_en_r <= 1'b1;
		end
		else
		begin
			div_r <= div_r + 16'h0001;
			step_en_r <= 1'b0;
		end
	end

	// text memory write port: sequencer clear or host data write
	always @*
	begin
		mem_we = 1'b0;
		mem_wa = ac_r;
		mem_wd = pwdata[7:0];
		if (state_r == ST_CLEAR)
		begin
			mem_we = step_en_r;
			mem_wa = clr_addr_r;
			mem_wd = `LCDI_CLEAR_CODE;
		end
		else if (!busy && wr_acc && paddr == `LCDI_OFS_DATA)
		begin
			mem_we = 1'b1;
		end
	end

	lcdi_txtmem #(
		.DEPTH(DEPTH),
		.AW(AW),
		.DW(8)
	) u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(mem_we),
		.wr_addr(mem_wa),
		.wr_data(mem_wd),
		.rd_addr(ac_r),
		.rd_data(mem_rd)
	);

	// read data and error decode
	always @*
	begin
		rdata_nxt = 32'h00000000;
		err_nxt = 1'b0;
		case (paddr)
		`LCDI_OFS_STATUS:
		begin
			rdata_nxt[`LCDI_ST_FLAG_BIT] = internal_op_flag;
			rdata_nxt[`LCDI_ST_AC_MSB:0] = ac_r;
			err_nxt = pwrite;
		end
		`LCDI_OFS_FUNC:
		begin
			rdata_nxt[`LCDI_FN_WIDTH_BIT] = bus_width_select;
			rdata_nxt[`LCDI_FN_LINES_BIT] = line_count_select;
			rdata_nxt[`LCDI_FN_FONT_BIT] = font_select;
			err_nxt = pwrite & busy;
		end
		`LCDI_OFS_DISP:
		begin
			rdata_nxt[`LCDI_DP_ON_BIT] = display_on;
			rdata_nxt[`LCDI_DP_CURSOR_BIT] = cursor_show;
			rdata_nxt[`LCDI_DP_BLINK_BIT] = blink_enable;
			err_nxt = pwrite & busy;
		end
		`LCDI_OFS_ENTRY:
		begin
			rdata_nxt[`LCDI_EN_INC_BIT] = addr_inc_r;
			rdata_nxt[`LCDI_EN_SHIFT_BIT] = disp_shift_r;
			err_nxt = pwrite & busy;
		end
		`LCDI_OFS_ADDR:
		begin
			rdata_nxt[AW-1:0] = ac_r;
			err_nxt = busy | (pwrite & (pwdata[AW-1:0] > LAST_ADDR));
		end
		`LCDI_OFS_DATA:
		begin
			rdata_nxt[7:0] = mem_rd;
			err_nxt = busy;
		end
		`LCDI_OFS_CTRL:
		begin
			err_nxt = pwrite & busy;
		end
		`LCDI_OFS_STATE:
		begin
			rdata_nxt[4:0] = state_r;
			rdata_nxt[AW+7:8] = clr_addr_r;
			err_nxt = pwrite;
		end
		default:
		begin
			err_nxt = 1'b1;
		end
		endcase
	end

	// bus answer: one wait state, then pready for one cycle
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= access;
			pslverr <= access & err_nxt;
			if (rd_acc)
				prdata <= err_nxt ? 32'h00000000 : rdata_nxt;
		end
	end

	// power-on sequencer and host-visible settings
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_CLEAR;
			internal_op_flag <= 1'b1;
			clr_addr_r <= {AW{1'b0}};
			ac_r <= {AW{1'b0}};
			bus_width_select <= `LCDI_DEF_WIDTH;
			line_count_select <= `LCDI_DEF_LINES;
			font_select <= `LCDI_DEF_FONT;
			display_on <= `LCDI_DEF_ON;
			cursor_show <= `LCDI_DEF_CURSOR;
			blink_enable <= `LCDI_DEF_BLINK;
			addr_inc_r <= `LCDI_DEF_INC;
			disp_shift_r <= `LCDI_DEF_SHIFT;
		end
		else
		begin
			case (state_r)
			ST_CLEAR:
			begin
				internal_op_flag <= 1'b1;
				if (step_en_r)
				begin
					clr_addr_r <= clr_addr_r + 7'h01;
					if (clr_addr_r == LAST_ADDR)
					begin
						clr_addr_r <= {AW{1'b0}};
						state_r <= ST_FUNC;
					end
				end
			end
			ST_FUNC:
			begin
				if (step_en_r)
				begin
					bus_width_select <= `LCDI_DEF_WIDTH;
					line_count_select <= `LCDI_DEF_LINES;
					font_select <= `LCDI_DEF_FONT;
					state_r <= ST_DISP;
				end
			end
			ST_DISP:
			begin
				if (step_en_r)
				begin
					display_on <= `LCDI_DEF_ON;
					cursor_show <= `LCDI_DEF_CURSOR;
					blink_enable <= `LCDI_DEF_BLINK;
					state_r <= ST_ENTRY;
				end
			end
			ST_ENTRY:
			begin
				if (step_en_r)
				begin
					addr_inc_r <= `LCDI_DEF_INC;
					disp_shift_r <= `LCDI_DEF_SHIFT;
					ac_r <= {AW{1'b0}};
					internal_op_flag <= 1'b0;
					state_r <= ST_READY;
				end
			end
			ST_READY:
			begin
				if (wr_acc && !err_nxt)
				begin
					case (paddr)
					`LCDI_OFS_FUNC:
					begin
						bus_width_select <= pwdata[`LCDI_FN_WIDTH_BIT];
						line_count_select <= pwdata[`LCDI_FN_LINES_BIT];
						font_select <= pwdata[`LCDI_FN_FONT_BIT];
					end
					`LCDI_OFS_DISP:
					begin
						display_on <= pwdata[`LCDI_DP_ON_BIT];
						cursor_show <= pwdata[`LCDI_DP_CURSOR_BIT];
						blink_enable <= pwdata[`LCDI_DP_BLINK_BIT];
					end
					`LCDI_OFS_ENTRY:
					begin
						addr_inc_r <= pwdata[`LCDI_EN_INC_BIT];
						disp_shift_r <= pwdata[`LCDI_EN_SHIFT_BIT];
					end
					`LCDI_OFS_ADDR:
					begin
						ac_r <= pwdata[AW-1:0];
					end
					`LCDI_OFS_DATA:
					begin
						ac_r <= ac_step(ac_r, addr_inc_r);
					end
					`LCDI_OFS_CTRL:
					begin
						// software rerun of the whole sequence
						if (pwdata[`LCDI_CT_RESTART_BIT])
						begin
							state_r <= ST_CLEAR;
							internal_op_flag <= 1'b1;
							clr_addr_r <= {AW{1'b0}};
						end
					end
					default:
					begin
						ac_r <= ac_r;
					end
					endcase
				end
				else if (rd_acc && !err_nxt && paddr == `LCDI_OFS_DATA)
				begin
					ac_r <= ac_step(ac_r, addr_inc_r);
				end
			end
			default:
			begin
				state_r <= ST_CLEAR;
				internal_op_flag <= 1'b1;
				clr_addr_r <= {AW{1'b0}};
			end
			endcase
		end
	end

endmodule

`default_nettype wire

/* File: tb/lcdi_init_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module lcdi_init_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic internal_op_flag,
	input wire logic bus_width_select,
	input wire logic line_count_select,
	input wire logic font_select,
	input wire logic display_on,
	input wire logic cursor_show,
	input wire logic blink_enable
);
	wire logic tk;
	assign tk = psel && penable && !pready;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_rst_busy: assert property (!$past(presetn) |-> internal_op_flag)
		else $error("flag low after reset");
	a_ready_lat: assert property (tk |=> pready)
		else $error("no answer one cycle after access");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_status_db7: assert property (tk && !pwrite && paddr == 8'h00 |=>
		prdata[7] == $past(internal_op_flag))
		else $error("status bit 7 differs from flag");
	a_busy_refuse: assert property (tk && pwrite && internal_op_flag &&
		(paddr == 8'h04 || paddr == 8'h08 || paddr == 8'h0C || paddr == 8'h18) |=> pslverr)
		else $error("write taken while busy");
	a_fn_default: assert property ($fell(internal_op_flag) |->
		bus_width_select && !line_count_select && !font_select)
		else $error("function defaults wrong at end of init");
	a_dp_default: assert property ($fell(internal_op_flag) |->
		!display_on && !cursor_show && !blink_enable)
		else $error("display defaults wrong at end of init");
	a_set_hold: assert property (!$past(internal_op_flag) && !$past(psel && pwrite) |->
		$stable({bus_width_select, line_count_select, font_select,
		display_on, cursor_show, blink_enable}))
		else $error("setting changed without cause");
endmodule
bind lcdi_init lcdi_init_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .internal_op_flag(internal_op_flag),
	.bus_width_select(bus_width_select), .line_count_select(line_count_select),
	.font_select(font_select), .display_on(display_on), .cursor_show(cursor_show),
	.blink_enable(blink_enable));
`default_nettype wire

/* File: tb/lcdi_host.sv */
`timescale 1ns/1ns
`default_nettype none
module lcdi_host (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	logic [31:0] pq;
	logic pe;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// request held until pready is seen at an edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		pq = prdata;
		pe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task poll;
		do
			xfer(1'b0, 8'h00, 32'h0);
		while (pq[7] !== 1'b0);
	endtask
	// software setup for when power-on init is not trusted
	task host_init;
		poll;
		xfer(1'b1, 8'h04, 32'h10);
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h0C, 32'h2);
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	wire psel, penable, pwrite, pready, pslverr, fl, bw, lc, fs, dn, cs, bl;
	wire [7:0] paddr;
	wire [31:0] pwdata, prdata;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	always #4 pclk = ~pclk;
	lcdi_init #(.STEP_CYC(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .internal_op_flag(fl),
		.bus_width_select(bw), .line_count_select(lc), .font_select(fs),
		.display_on(dn), .cursor_show(cs), .blink_enable(bl));
	lcdi_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x)
		begin
			n_fail++;
			$display("CHECK FAILED %0t saw %h want %h", $time, s, x);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
		host.xfer(1'b0, a, 32'h0);
		chk(host.pq, x);
		chk({31'h0, host.pe}, {31'h0, ex});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic ex);
		host.xfer(1'b1, a, d);
		chk({31'h0, host.pe}, {31'h0, ex});
	endtask
	task sets(input logic [5:0] x);
		chk({26'h0, bw, lc, fs, dn, cs, bl}, {26'h0, x});
	endtask
	task busy(input logic x);
		chk({31'h0, fl}, {31'h0, x});
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			n_fail++;
			final_report;
		end
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		busy(1'b1);
		host.xfer(1'b0, 8'h00, 32'h0);
		chk({31'h0, host.pq[7]}, 32'h1);
		wr(8'h04, 32'h0, 1'b1);
		host.poll;
		busy(1'b0);
		sets(6'h20);
		rd(8'h00, 32'h0, 1'b0);
		rd(8'h04, 32'h10, 1'b0);
		rd(8'h08, 32'h0, 1'b0);
		rd(8'h0C, 32'h2, 1'b0);
		repeat (80) rd(8'h14, 32'h20, 1'b0);
		rd(8'h00, 32'h0, 1'b0);
		$display("test power-on done");
		wr(8'h14, 32'h41, 1'b0);
		wr(8'h0C, 32'h0, 1'b0);
		rd(8'h14, 32'h20, 1'b0);
		rd(8'h14, 32'h41, 1'b0);
		rd(8'h00, 32'h4F, 1'b0);
		wr(8'h10, 32'h5, 1'b0);
		rd(8'h10, 32'h5, 1'b0);
		wr(8'h08, 32'h7, 1'b0);
		wr(8'h04, 32'h1C, 1'b0);
		sets(6'h3F);
		rd(8'h20, 32'h0, 1'b1);
		wr(8'h00, 32'h0, 1'b1);
		wr(8'h10, 32'h50, 1'b1);
		wr(8'h18, 32'h1, 1'b0);
		@(posedge pclk);
		busy(1'b1);
		host.poll;
		sets(6'h20);
		rd(8'h14, 32'h20, 1'b0);
		$display("test restart done");
		wr(8'h18, 32'h1, 1'b0);
		repeat (20) @(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		busy(1'b1);
		wr(8'h0C, 32'h0, 1'b1);
		host.host_init;
		rd(8'h0C, 32'h2, 1'b0);
		$display("test reset done");
		final_report;
	end
endmodule
`default_nettype wire
